// >>> logic/pcr_core_reset.sv
// What this block does
// - Drive a fixed-frequency core clock output.
// - Core reset is active low, pulls datapath reset and reset status low.
// - Output active-low reset status from either reset.
// - Board reset pulls datapath reset and reset status low.
// - Each instance has its own board reset pin.
//
// Purpose: Clock and reset boundary of one core instance.
// Assumes: sys_clk is the free-running reference clock.
// Notes: Reset pins are asynchronous and pass a 3-stage filter.
`timescale 1ns/1ps
module pcr_core_reset #(
   parameter int STRETCH = pcr_pkg::RST_STRETCH_CYC
)
(
   // Clock and system reset
   input wire logic sys_clk,
   input wire logic rst_n,
   // Reset pins of this instance
   input wire logic coreRst_n,
   input wire logic boardRst_n,
   // Core clock and reset status
   output logic coreClk,
   output logic resetStatus_n,
   // Datapath reset seen by the core internals
   output logic datapathRst_n
);
   // Synchroniser chains, stage 0 read only by stage 1
   logic [2:0] coreSync;
   logic [2:0] boardSync;
   // Filtered, debounced levels
   logic coreLvl;
   logic boardLvl;
   // Core reset state and stretch counter
   pcr_pkg::pcr_state_t state;
   logic [pcr_pkg::RST_CNT_W-1:0] holdCnt;
   // Cycles spent in hold since it last started, a checking aid only
   logic [pcr_pkg::RST_CNT_W:0] holdAge;
   // Core clock divider count
   logic [pcr_pkg::RST_CNT_W-1:0] divCnt;
   // Falling edge on the filtered core reset
   logic coreFall;

   // Three-stage synchronisers for both pins
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         coreSync <= 3'h7;
         boardSync <= 3'h7;
      end
      else
      begin
         coreSync <= {coreSync[1:0], coreRst_n};
         boardSync <= {boardSync[1:0], boardRst_n};
      end
   end

   // A level changes only when stages two and three agree
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         coreLvl <= 1'h1;
         boardLvl <= 1'h1;
      end
      else
      begin
         if (coreSync[1] == coreSync[2])
            coreLvl <= coreSync[2];
         if (boardSync[1] == boardSync[2])
            boardLvl <= boardSync[2];
      end
   end

   // Edge, not level: only a falling edge starts a core reset
   assign coreFall = coreLvl && (coreSync[1] == coreSync[2])
                     && !coreSync[2];

   // Core reset lasts STRETCH cycles from its last falling edge; holding the pin low does
   // not extend it, so custom logic cannot lean on the pin level
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         state <= pcr_pkg::PCR_HOLD;
         holdCnt <= '0;
      end
      else
      begin
         unique case (state)
            pcr_pkg::PCR_RUN:
            begin
               if (coreFall)
               begin
                  state <= pcr_pkg::PCR_HOLD;
                  holdCnt <= '0;
               end
            end
            pcr_pkg::PCR_HOLD:
            begin
               if (coreFall)
                  holdCnt <= '0;
               else if (holdCnt ==
                        pcr_pkg::RST_CNT_W'(STRETCH - 1))
                  state <= pcr_pkg::PCR_RUN;
               else
                  holdCnt <= holdCnt + 1'h1;
            end
            default:
               state <= pcr_pkg::PCR_HOLD;
         endcase
      end
   end

   // Independent age of the hold; a level-held reset would let it run
   // past the stretch, which the edge-only check below would catch
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
         holdAge <= '0;
      else if (coreFall || (state == pcr_pkg::PCR_RUN))
         holdAge <= '0;
      else if (holdAge != '1)
         holdAge <= holdAge + 1'h1;
   end

   // Fixed-ratio core clock from the free-running reference
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         divCnt <= '0;
         coreClk <= 1'h0;
      end
      else if (divCnt ==
               pcr_pkg::RST_CNT_W'(pcr_pkg::CORE_HALF_DIV - 1))
      begin
         divCnt <= '0;
         coreClk <= !coreClk;
      end
      else
         divCnt <= divCnt + 1'h1;
   end

   // Registered reset outputs, either source pulls status low
   always_ff @(posedge sys_clk)
   begin
      if (!rst_n)
      begin
         resetStatus_n <= 1'h0;
         datapathRst_n <= 1'h0;
      end
      else
      begin
         resetStatus_n <= (state == pcr_pkg::PCR_RUN)
                          && boardLvl;
         datapathRst_n <= boardLvl && (state == pcr_pkg::PCR_RUN);
      end
   end

   // Board reset low pulls status low on the next cycle
   AST_BOARD_STATUS: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !boardLvl |=> !resetStatus_n)
      else $error("status high while board reset low");

   // Board reset clears the datapath reset output
   AST_BOARD_DP: assert property (@(posedge sys_clk)
      disable iff (!rst_n) !boardLvl |=> !datapathRst_n)
      else $error("datapath not reset by board reset");

   // A core edge starts the hold state
   AST_CORE_EDGE: assert property (@(posedge sys_clk)
      disable iff (!rst_n) coreFall |=> state == pcr_pkg::PCR_HOLD)
      else $error("core edge did not start reset");

   // Hold never outlives the stretch, however long the pin stays low
   sequence s_hold_start;
      state == pcr_pkg::PCR_RUN ##1 state == pcr_pkg::PCR_HOLD;
   endsequence
   AST_EDGE_ONLY: assert property (@(posedge sys_clk)
      disable iff (!rst_n) state == pcr_pkg::PCR_HOLD
      |-> holdAge < (pcr_pkg::RST_CNT_W + 1)'(STRETCH))
      else $error("core reset held by level");

   // A fresh core reset starts its hold from zero
   AST_HOLD_FRESH: assert property (@(posedge sys_clk)
      disable iff (!rst_n) s_hold_start |-> holdCnt == '0 && holdAge == '0)
      else $error("core reset hold did not start fresh");

   // A core reset hold also keeps the datapath in reset
   AST_CORE_DP: assert property (@(posedge sys_clk)
      disable iff (!rst_n) state == pcr_pkg::PCR_HOLD |=> !datapathRst_n)
      else $error("datapath released during core reset hold");

   // A core reset hold pulls the status low on the next edge
   AST_CORE_STATUS: assert property (@(posedge sys_clk)
      disable iff (!rst_n) state == pcr_pkg::PCR_HOLD |=> !resetStatus_n)
      else $error("status high during core reset hold");

   // Core clock toggles every half period
   AST_CLK_RUN: assert property (@(posedge sys_clk)
      disable iff (!rst_n) coreClk |-> ##[1:2] !coreClk)
      else $error("core clock stalled");

   // Status high implies both sources released
   AST_STATUS_SRC: assert property (@(posedge sys_clk)
      disable iff (!rst_n) resetStatus_n |->
      $past(boardLvl) && $past(state) == pcr_pkg::PCR_RUN)
      else $error("status released with a reset active");

   // Filter follows two agreeing stages
   AST_FILTER: assert property (@(posedge sys_clk)
      disable iff (!rst_n) (boardSync[2] == boardSync[1])
      |=> boardLvl == $past(boardSync[2]))
      else $error("board filter mismatch");

   // Hold counter never passes the stretch length
   AST_CNT_BOUND: assert property (@(posedge sys_clk)
      disable iff (!rst_n)
      holdCnt <= pcr_pkg::RST_CNT_W'(STRETCH - 1))
      else $error("hold counter overrun");
endmodule : pcr_core_reset

// >>> logic/pcr_pkg.sv
// Purpose: Shared constants for the core clock and reset boundary.
// Assumes: One system clock at 10 MHz.
// Notes: Counts are in sys_clk cycles.
package pcr_pkg;
   // Clock period in nanoseconds
   localparam int CLK_PERIOD_NS = 100;
   // Core clock divide ratio, half period in sys_clk cycles
   localparam int CORE_HALF_DIV = 1;
   // Reset pulse stretch after a falling edge, in nanoseconds
   localparam int RST_STRETCH_NS = 800;
   // Stretch length derived from the clock rate, rounded up
   localparam int RST_STRETCH_CYC =
      (RST_STRETCH_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // Width of the stretch counter
   localparam int RST_CNT_W = 4;
   // Reset states
   typedef enum logic [1:0]
   {
      PCR_RUN = 2'h0,
      PCR_HOLD = 2'h1
   } pcr_state_t;
endpackage : pcr_pkg

// >>> testbench/pcr_app_model.sv
// Purpose: Application side that forms the core reset pin.
// Assumes: Board and soft resets are both active low.
// Notes: Status release is retimed to the application clock.
`timescale 1ns/1ps
module pcr_app_model
(
   // Application clock
   input wire logic sys_clk,
   // Reset sources and status
   input wire logic boardRst_n,
   input wire logic softRst_n,
   input wire logic resetStatus_n,
   // Core pin and local reset
   output logic coreRst_n,
   output logic appRst_n
);
   // Two-stage retimer
   logic [1:0] statusSync;
   // Either source asserts the pin; never left floating
   assign coreRst_n = boardRst_n & softRst_n;
   // Assert at once, release two clocks later to avoid metastable exit
   always_ff @(posedge sys_clk or negedge resetStatus_n)
   begin
      if (!resetStatus_n)
         statusSync <= 2'h0;
      else
         statusSync <= {statusSync[0], 1'h1};
   end
   assign appRst_n = statusSync[1];
endmodule : pcr_app_model

// >>> testbench/pcr_core_clock_reset_iface_test.sv
// Purpose: Self-checking bench for the clock and reset boundary.
// Assumes: Stretch left at its package default length.
// Notes: Pins change at the rising edge only.
`timescale 1ns/1ps
module pcr_core_clock_reset_iface_test;
   localparam int STR = pcr_pkg::RST_STRETCH_CYC;
   // Free-running reference, never stopped
   logic sys_clk = 1'h0;
   logic rst_n = 1'h0;
   logic boardRst_n = 1'h1;
   logic softRst_n = 1'h1;
   logic coreRst_n, coreClk, resetStatus_n, datapathRst_n, appRst_n;
   int fail_count = 0;
   int num_checks = 0;
   initial
   begin
      forever #50 sys_clk = ~sys_clk;
   end
   pcr_core_reset #(.STRETCH(STR)) uut (.sys_clk(sys_clk), .rst_n(rst_n),
      .coreRst_n(coreRst_n), .boardRst_n(boardRst_n), .coreClk(coreClk),
      .resetStatus_n(resetStatus_n), .datapathRst_n(datapathRst_n));
   pcr_app_model app (.sys_clk(sys_clk), .boardRst_n(boardRst_n),
      .softRst_n(softRst_n), .resetStatus_n(resetStatus_n),
      .coreRst_n(coreRst_n), .appRst_n(appRst_n));
   // Count and report a compare
   task automatic check(input logic [7:0] seen, input logic [7:0] exp);
      num_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask : check
   // Bounded wait for a status level, n counts the falling edges waited
   task automatic wait_status(input logic lvl, input int maxc, output int n);
      for (n = 0; n < maxc && resetStatus_n !== lvl; n++)
         @(negedge sys_clk);
   endtask : wait_status
   // Leave reset, then the core clock flips every cycle
   task automatic test_startup();
      logic prev;
      int n;
      wait_status(1'h1, 20, n);
      check({6'h0, resetStatus_n, datapathRst_n}, 8'h3);
      check({7'h0, appRst_n}, 8'h0);
      prev = coreClk;
      repeat (4)
      begin
         @(negedge sys_clk);
         check({7'h0, coreClk}, {7'h0, ~prev});
         prev = coreClk;
      end
      check({7'h0, appRst_n}, 8'h1);
   endtask : test_startup
   // A held-low core pin must not keep the core in reset
   task automatic test_core_edge();
      int n;
      @(posedge sys_clk);
      softRst_n <= 1'h0;
      wait_status(1'h0, 8, n);
      check({6'h0, resetStatus_n, datapathRst_n}, 8'h0);
      wait_status(1'h1, STR + 10, n);
      check(8'(n), 8'(STR));
      check({5'h0, coreRst_n, resetStatus_n, datapathRst_n}, 8'h3);
      @(posedge sys_clk);
      softRst_n <= 1'h1;
   endtask : test_core_edge
   // Board reset holds for as long as it is low
   task automatic test_board();
      int n;
      @(posedge sys_clk);
      boardRst_n <= 1'h0;
      wait_status(1'h0, 8, n);
      repeat (3 * STR) @(negedge sys_clk);
      check({6'h0, resetStatus_n, datapathRst_n}, 8'h0);
      @(posedge sys_clk);
      boardRst_n <= 1'h1;
      wait_status(1'h1, STR + 12, n);
      check({6'h0, resetStatus_n, datapathRst_n}, 8'h3);
   endtask : test_board
   // A second falling edge four cycles into the hold restarts the count
   task automatic test_core_restart();
      int n;
      @(posedge sys_clk);
      softRst_n <= 1'h0;
      repeat (2) @(posedge sys_clk);
      softRst_n <= 1'h1;
      repeat (2) @(posedge sys_clk);
      softRst_n <= 1'h0;
      wait_status(1'h0, 8, n);
      wait_status(1'h1, STR + 16, n);
      check(8'(n), 8'(STR + 4));
      @(posedge sys_clk);
      softRst_n <= 1'h1;
   endtask : test_core_restart
   // Verdict and end of run
   task automatic print_verdict();
      if (fail_count == 0 && num_checks > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : print_verdict
   initial
   begin
      repeat (12) @(posedge sys_clk);
      rst_n <= 1'h1;
      test_startup();
      test_core_edge();
      test_board();
      test_core_restart();
      print_verdict();
   end
   // Watchdog, well beyond the expected run
   initial
   begin
      #(400 * 100);
      fail_count++;
      print_verdict();
   end
endmodule : pcr_core_clock_reset_iface_test
